// ---- verilog/pxr_ext_cap_regs.sv ----
// extended capability register bank for a pci express function:
// root status, device control 2, link control 2, serial number,
// power budget and virtual channel headers.
// assumes one-cycle read/write strobes from the configuration core
// and a preload write port driven by the serial eeprom loader.
// Operation
// - pme status sets on pme, write-one clears
// - root status visible only in root complex mode
// - completion timeout code, bits 3:0, resets 3h
// - link control 2 only in legacy adapter mode
// - target speed 0001b 2.5GT/s, 0010b 5GT/s
// - 5GT/s: bit selects -6/-3.5dB; 2.5GT/s: -3.5dB
// - bit 11 inserts skip sets in compliance
// - bit 12 sets compliance de-emphasis via bit 4
// - modified compliance honoured only function 0 port 0
// - autonomous speed disable reserved, never blocks speedup
// - status bit 16 reports current de-emphasis
// - one shared physical 64-bit serial number
// - company id upper 24, extension lower 40
// - serial header id 0003h, ver 1, next FB4h
// - power budget header id 0004h, next 148h
// - vc header id 0002h, version 1, next 950h
// - index picks power budget dword 0 or 1
// - entry base power 7:0, scale 9:8
// - pm state 14:13, substate 12:10 zero
// - condition type in bits 17:15
// - power rail in bits 20:18
// - extended vc count reads 000b
module pxr_ext_cap_regs
  import pxr_pkg::*;
#(
  parameter logic [31:0] SN_LOW_RST  = PXR_SN_LOW_RST,
  parameter logic [31:0] SN_HIGH_RST = PXR_SN_HIGH_RST,
  parameter int          PB_ENTRIES  = 2
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  // configuration access
  input  wire logic        cfg_rd,
  input  wire logic        cfg_wr,
  input  wire logic [11:0] cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_ack,
  // eeprom preload of read-only fields and of read/write register defaults
  input  wire logic        ee_wr,
  input  wire logic [11:0] ee_addr,
  input  wire logic [31:0] ee_wdata,
  // modes and link state
  input  wire logic        root_complex_mode,
  input  wire logic        legacy_adapter_mode,
  input  wire logic        func0_port0,
  input  wire logic        link_at_5gt,
  input  wire logic        in_poll_compliance,
  input  wire logic        pme_event,
  // controls toward the link and transaction layers
  output logic      [3:0]  cpl_timeout_code,
  output logic      [3:0]  target_speed,
  output logic             tx_deemph,
  output logic             compliance_sos,
  output logic             enter_compliance,
  output logic             enter_mod_compliance,
  output logic      [2:0]  tx_margin,
  output logic             autonomous_speed_ok
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [31:0] root_q;
  logic [31:0] dev_cap2_q;
  logic [31:0] dev_ctl2_q;
  logic [31:0] link2_q;
  logic [63:0] serial_q;
  logic [7:0]  pb_index_q;
  logic [31:0] pb_entry_q [PB_ENTRIES];
  logic        pb_sysalloc_q;
  logic        deemph_q;
  logic        comp_by_bit4_q;
  logic [31:0] rdata_d;

  // merge a write under byte enables and a writable-bit mask
  function automatic logic [31:0] merge_wr(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be,
                                           input logic [31:0] wm);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
    return (old & ~m) | (wd & m);
  endfunction

  // keep only the defined bits of a power budget entry
  function automatic logic [31:0] pb_clean(input logic [31:0] v);
    logic [31:0] r;
    r = '0;
    r[PXR_PB_USED_BITS-1:0] = v[PXR_PB_USED_BITS-1:0];
    r[PXR_SUBST_LSB +: 3]   = PXR_SUBST_VAL;
    return r;
  endfunction

  logic wr_root;
  logic wr_link2;
  logic pb_sel_ok;
  // hidden registers swallow writes, like reserved space
  assign wr_root   = cfg_wr && cfg_addr == PXR_OFS_ROOT_STAT
                     && root_complex_mode;
  assign wr_link2  = cfg_wr && cfg_addr == PXR_OFS_LINK_CTL2
                     && legacy_adapter_mode;
  assign pb_sel_ok = pb_index_q < PXR_PB_ENTRIES;

  // a preload steers a merge only when it targets that very register,
  // so a host write in the same cycle is never fed eeprom data
  logic        ee_ctl2;
  logic        ee_link2;
  logic [31:0] link2_ee_mask;
  assign ee_ctl2  = ee_wr && ee_addr == PXR_OFS_DEV_CTL2;
  assign ee_link2 = ee_wr && ee_addr == PXR_OFS_LINK_CTL2;

  // the eeprom may also load the hardware-initialised de-emphasis bit
  always_comb begin
    link2_ee_mask                 = PXR_LINK2_WMASK;
    link2_ee_mask[PXR_SEL_DEEMPH] = 1'b1;
  end

  // ****************************************************************
  // root status
  // ****************************************************************
  // set beats clear so a pme arriving with the clear is kept
  always_ff @(posedge mclk) begin
    if (reset) begin
      root_q <= '0;
    end else begin
      if (ee_wr && ee_addr == PXR_OFS_ROOT_STAT) begin
        root_q[15:0]             <= ee_wdata[15:0];
        root_q[PXR_PME_PEND_BIT] <= ee_wdata[PXR_PME_PEND_BIT];
      end
      if (wr_root && cfg_be[2] && cfg_wdata[PXR_PME_STAT_BIT])
        root_q[PXR_PME_STAT_BIT] <= 1'b0;
      if (pme_event)
        root_q[PXR_PME_STAT_BIT] <= 1'b1;
    end
  end

  // ****************************************************************
  // device capability and control 2
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      dev_cap2_q <= '0;
      dev_ctl2_q <= {28'h0, PXR_CTO_RST[3:0]};
    end else begin
      if (ee_wr && ee_addr == PXR_OFS_DEV_CAP2)
        dev_cap2_q <= {27'h0, ee_wdata[4:0]};
      if ((cfg_wr && cfg_addr == PXR_OFS_DEV_CTL2) || ee_ctl2)
        dev_ctl2_q <= merge_wr(dev_ctl2_q,
                               ee_ctl2 ? ee_wdata : cfg_wdata,
                               ee_ctl2 ? 4'hf : cfg_be,
                               PXR_DEV2_WMASK);
    end
  end

  // ****************************************************************
  // link control 2
  // ****************************************************************
  // bit 5 stays out of the writable mask, so it always reads zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      link2_q <= {28'h0, PXR_SPEED_RST};
    end else if (wr_link2 || ee_link2) begin
      link2_q <= merge_wr(link2_q,
                          ee_link2 ? ee_wdata : cfg_wdata,
                          ee_link2 ? 4'hf : cfg_be,
                          ee_link2 ? link2_ee_mask
                                   : PXR_LINK2_WMASK);
    end
  end

  // remember whether compliance was entered through bit 4
  always_ff @(posedge mclk) begin
    if (reset)
      comp_by_bit4_q <= 1'b0;
    else if (!in_poll_compliance)
      comp_by_bit4_q <= link2_q[PXR_ENTER_COMP];
  end

  // de-emphasis in use; 2.5 GT/s ignores the selectable bit
  always_ff @(posedge mclk) begin
    if (reset)
      deemph_q <= PXR_DEEMPH_6DB;
    else if (in_poll_compliance && comp_by_bit4_q)
      deemph_q <= link2_q[PXR_COMP_DEEMPH];
    else if (link_at_5gt)
      deemph_q <= link2_q[PXR_SEL_DEEMPH];
    else
      deemph_q <= PXR_DEEMPH_3DB5;
  end

  // control outputs toward the link logic
  assign cpl_timeout_code     = dev_ctl2_q[3:0];
  // reserved speed codes fall back to the 5 GT/s default
  assign target_speed         = (link2_q[3:0] == PXR_SPEED_2G5) ?
                                PXR_SPEED_2G5 : PXR_SPEED_5G;
  assign tx_deemph            = deemph_q;
  assign compliance_sos       = link2_q[PXR_COMP_SOS];
  assign enter_compliance     = link2_q[PXR_ENTER_COMP];
  assign enter_mod_compliance = link2_q[PXR_MOD_COMP]
                                && func0_port0;
  assign tx_margin            = link2_q[PXR_MARGIN_LSB +: 3];
  assign autonomous_speed_ok  = 1'b1;

  // ****************************************************************
  // serial number and power budget
  // ****************************************************************
  // one copy serves every function; only the eeprom loads it
  always_ff @(posedge mclk) begin
    if (reset) begin
      serial_q <= {SN_HIGH_RST, SN_LOW_RST};
    end else if (ee_wr && ee_addr == PXR_OFS_SN_LOW) begin
      serial_q[31:0] <= ee_wdata;
    end else if (ee_wr && ee_addr == PXR_OFS_SN_HIGH) begin
      serial_q[63:32] <= ee_wdata;
    end
  end

  // host write of the index, merged under its byte enables
  logic [31:0] pb_index_w;
  assign pb_index_w = merge_wr({24'h0, pb_index_q}, cfg_wdata, cfg_be,
                               PXR_INDEX_WMASK);

  // index register; the eeprom loads entries through it as well
  always_ff @(posedge mclk) begin
    if (reset) begin
      pb_index_q <= '0;
    end else if (ee_wr && ee_addr == PXR_OFS_PB_INDEX) begin
      pb_index_q <= ee_wdata[7:0];
    end else if (cfg_wr && cfg_addr == PXR_OFS_PB_INDEX) begin
      pb_index_q <= pb_index_w[7:0];
    end
  end

  // entries are read-only to the host; fields land in place
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < PB_ENTRIES; i++)
        pb_entry_q[i] <= '0;
      pb_sysalloc_q <= 1'b1;
    end else begin
      if (ee_wr && ee_addr == PXR_OFS_PB_ENTRY && pb_sel_ok)
        pb_entry_q[pb_index_q[0]] <=
          pb_clean(ee_wdata);
      if (ee_wr && ee_addr == PXR_OFS_PB_FLAGS)
        pb_sysalloc_q <= ee_wdata[0];
    end
  end

  // ****************************************************************
  // read decode and answer
  // ****************************************************************
  // unmapped and hidden offsets answer zero
  always_comb begin
    rdata_d = '0;
    case (cfg_addr)
      PXR_OFS_ROOT_STAT: if (root_complex_mode) rdata_d = root_q;
      PXR_OFS_DEV_CAP2:  rdata_d = dev_cap2_q;
      PXR_OFS_DEV_CTL2:  rdata_d = dev_ctl2_q;
      PXR_OFS_LINK_CTL2: begin
        if (legacy_adapter_mode) begin
          rdata_d = link2_q;
          rdata_d[PXR_CUR_DEEMPH] = deemph_q;
        end
      end
      PXR_OFS_SN_HDR:    rdata_d = PXR_SN_HDR_VAL;
      PXR_OFS_SN_LOW:    rdata_d = serial_q[31:0];
      PXR_OFS_SN_HIGH:   rdata_d = serial_q[63:32];
      PXR_OFS_PB_HDR:    rdata_d = PXR_PB_HDR_VAL;
      PXR_OFS_PB_INDEX:  rdata_d = {24'h0, pb_index_q};
      PXR_OFS_PB_ENTRY:  if (pb_sel_ok)
                           rdata_d = pb_entry_q[pb_index_q[0]];
      PXR_OFS_PB_FLAGS:  rdata_d = {31'h0, pb_sysalloc_q};
      PXR_OFS_VC_HDR:    rdata_d = PXR_VC_HDR_VAL;
      PXR_OFS_VC_CAP1:   rdata_d = {29'h0, PXR_VC_EXT_CNT};
      default:           rdata_d = '0;
    endcase
  end

  // answer one cycle after any strobe; writes return zero data
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_ack   <= 1'b0;
      cfg_rdata <= '0;
    end else begin
      cfg_ack   <= cfg_rd || cfg_wr;
      cfg_rdata <= cfg_rd ? rdata_d : '0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_pme_set_sticky: assert property (
    @(posedge mclk) disable iff (reset)
    pme_event |=> root_q[PXR_PME_STAT_BIT])
    else $error("pme status not set after pme event");

  chk_pme_w1c_clear: assert property (
    @(posedge mclk) disable iff (reset)
    (wr_root && cfg_be[2] && cfg_wdata[PXR_PME_STAT_BIT] && !pme_event)
    |=> !root_q[PXR_PME_STAT_BIT])
    else $error("pme status not cleared by write one");

  chk_root_hidden_zero: assert property (
    @(posedge mclk) disable iff (reset)
    (cfg_rd && cfg_addr == PXR_OFS_ROOT_STAT && !root_complex_mode)
    |=> cfg_ack && cfg_rdata == 32'h0)
    else $error("root status visible outside root complex mode");

  chk_link2_hidden_w: assert property (
    @(posedge mclk) disable iff (reset)
    (cfg_wr && cfg_addr == PXR_OFS_LINK_CTL2 && !legacy_adapter_mode
     && !ee_wr) |=> $stable(link2_q))
    else $error("link control 2 written in enhanced mode");

  chk_deemph_slow_link: assert property (
    @(posedge mclk) disable iff (reset)
    (!link_at_5gt && !in_poll_compliance)[*2]
    |-> tx_deemph == PXR_DEEMPH_3DB5)
    else $error("de-emphasis not -3.5 dB at 2.5 GT/s");

  chk_comp_deemph_sel: assert property (
    @(posedge mclk) disable iff (reset)
    (in_poll_compliance && comp_by_bit4_q)
    |=> tx_deemph == $past(link2_q[PXR_COMP_DEEMPH]))
    else $error("compliance de-emphasis not applied");

  chk_mod_comp_gate: assert property (
    @(posedge mclk) disable iff (reset)
    !func0_port0 |-> !enter_mod_compliance)
    else $error("modified compliance honoured off function 0");

  chk_hw_speed_rsvd: assert property (
    @(posedge mclk) disable iff (reset)
    wr_link2 |=> !link2_q[PXR_HW_SPD_DIS] && autonomous_speed_ok)
    else $error("hardware autonomous speed disable became set");

  chk_cur_deemph_rd: assert property (
    @(posedge mclk) disable iff (reset)
    (cfg_rd && cfg_addr == PXR_OFS_LINK_CTL2 && legacy_adapter_mode)
    |=> cfg_rdata[PXR_CUR_DEEMPH] == $past(deemph_q))
    else $error("status bit 16 differs from de-emphasis in use");

  chk_pb_range_zero: assert property (
    @(posedge mclk) disable iff (reset)
    (cfg_rd && cfg_addr == PXR_OFS_PB_ENTRY && !pb_sel_ok)
    |=> cfg_rdata == 32'h0)
    else $error("power budget index beyond two entries returned data");

  chk_vc_header_read: assert property (
    @(posedge mclk) disable iff (reset)
    (cfg_rd && cfg_addr == PXR_OFS_VC_HDR) ##1 cfg_ack
    |-> cfg_rdata == PXR_VC_HDR_VAL)
    else $error("virtual channel header wrong");

endmodule

// ---- verilog/pxr_pkg.sv ----
// ****************************************************************
// pxr_pkg: offsets, field positions, reset values and identities
// ****************************************************************
// shared by the extended capability register bank; no process here
package pxr_pkg;
  // ***************************************
  // register offsets (byte addresses)
  // ***************************************
  localparam logic [11:0] PXR_OFS_ROOT_STAT = 12'h088;
  localparam logic [11:0] PXR_OFS_DEV_CAP2  = 12'h08c;
  localparam logic [11:0] PXR_OFS_DEV_CTL2  = 12'h090;
  localparam logic [11:0] PXR_OFS_LINK_CTL2 = 12'h098;
  localparam logic [11:0] PXR_OFS_SN_HDR    = 12'h100;
  localparam logic [11:0] PXR_OFS_SN_LOW    = 12'h104;
  localparam logic [11:0] PXR_OFS_SN_HIGH   = 12'h108;
  localparam logic [11:0] PXR_OFS_PB_HDR    = 12'h138;
  localparam logic [11:0] PXR_OFS_PB_INDEX  = 12'h13c;
  localparam logic [11:0] PXR_OFS_PB_ENTRY  = 12'h140;
  localparam logic [11:0] PXR_OFS_PB_FLAGS  = 12'h144;
  localparam logic [11:0] PXR_OFS_VC_HDR    = 12'h148;
  localparam logic [11:0] PXR_OFS_VC_CAP1   = 12'h14c;

  // ***************************************
  // capability headers: next[31:20] ver[19:16] id[15:0]
  // ***************************************
  localparam logic [31:0] PXR_SN_HDR_VAL = {12'hfb4, 4'h1, 16'h0003};
  localparam logic [31:0] PXR_PB_HDR_VAL = {12'h148, 4'h1, 16'h0004};
  localparam logic [31:0] PXR_VC_HDR_VAL = {12'h950, 4'h1, 16'h0002};
  localparam logic [2:0]  PXR_VC_EXT_CNT = 3'h0;

  // ***************************************
  // field positions
  // ***************************************
  localparam int PXR_PME_STAT_BIT = 16;
  localparam int PXR_PME_PEND_BIT = 17;
  localparam int PXR_CTO_DIS_BIT  = 4;
  localparam int PXR_ENTER_COMP   = 4;
  localparam int PXR_HW_SPD_DIS   = 5;
  localparam int PXR_SEL_DEEMPH   = 6;
  localparam int PXR_MARGIN_LSB   = 7;
  localparam int PXR_MOD_COMP     = 10;
  localparam int PXR_COMP_SOS     = 11;
  localparam int PXR_COMP_DEEMPH  = 12;
  localparam int PXR_CUR_DEEMPH   = 16;
  localparam int PXR_PB_USED_BITS = 21;
  localparam int PXR_SUBST_LSB    = 10;

  // ***************************************
  // reset values and encodings
  // ***************************************
  localparam logic [7:0] PXR_CTO_RST     = 8'h13;
  localparam logic [3:0] PXR_SPEED_2G5   = 4'h1;
  localparam logic [3:0] PXR_SPEED_5G    = 4'h2;
  localparam logic [3:0] PXR_SPEED_RST   = 4'h2;
  localparam logic       PXR_DEEMPH_6DB  = 1'b0;
  localparam logic       PXR_DEEMPH_3DB5 = 1'b1;
  localparam logic [2:0] PXR_SUBST_VAL   = 3'h0;
  localparam logic [7:0] PXR_PB_ENTRIES  = 8'h02;
  // writable masks of the read/write registers
  localparam logic [31:0] PXR_LINK2_WMASK = 32'h0000_1f9f;
  localparam logic [31:0] PXR_DEV2_WMASK  = 32'h0000_001f;
  localparam logic [31:0] PXR_INDEX_WMASK = 32'h0000_00ff;
  localparam logic [31:0] PXR_ROOT_W1C    = 32'h0001_0000;
  // identity: arbitrary neutral values, not any real part
  localparam logic [31:0] PXR_SN_LOW_RST  = 32'h0000_0001;
  localparam logic [31:0] PXR_SN_HIGH_RST = 32'h1234_5600;
endpackage

// ---- tb/pxr_host_model.sv ----
// ****************************************************************
// pxr_host_model: configuration requester facing the register bank
// ****************************************************************
// assumes one-cycle read/write strobes answered by a one-cycle ack
// one edge later; requests are launched 1 ns after a rising edge
module pxr_host_model (
  input  wire logic        mclk,
  output logic             cfg_rd,
  output logic             cfg_wr,
  output logic      [11:0] cfg_addr,
  output logic      [3:0]  cfg_be,
  output logic      [31:0] cfg_wdata,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    cfg_rd    = 1'b0;
    cfg_wr    = 1'b0;
    cfg_addr  = 12'h000;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end

  // one transfer: strobe held for exactly the edge that takes it, answer
  // picked up in the cycle it stands; released lines show the inverse so
  // a stale value can never pass for a live one
  task automatic xfer(input  logic        wr,
                      input  logic [11:0] a,
                      input  logic [3:0]  be,
                      input  logic [31:0] wd,
                      output logic [31:0] rdat,
                      output logic        ack);
    @(posedge mclk);
    #1;
    cfg_rd    = !wr;
    cfg_wr    = wr;
    cfg_addr  = a;
    cfg_be    = be;
    cfg_wdata = wd;
    @(posedge mclk);
    #1;
    rdat      = cfg_rdata;
    ack       = cfg_ack;
    cfg_rd    = 1'b0;
    cfg_wr    = 1'b0;
    cfg_addr  = ~a;
    cfg_be    = ~be;
    cfg_wdata = ~wd;
  endtask
endmodule

// ---- tb/testbench.sv ----
// ****************************************************************
// testbench: self-checking bench for the extended capability bank
// ****************************************************************
// assumes the host model for config cycles; the bench drives modes,
// link state, pme events and the eeprom preload port directly
module testbench;
  import pxr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk;
  logic        reset;
  logic        cfg_rd;
  logic        cfg_wr;
  logic [11:0] cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata;
  logic [31:0] cfg_rdata;
  logic        cfg_ack;
  logic        ee_wr;
  logic [11:0] ee_addr;
  logic [31:0] ee_wdata;
  logic        root_complex_mode;
  logic        legacy_adapter_mode;
  logic        func0_port0;
  logic        link_at_5gt;
  logic        in_poll_compliance;
  logic        pme_event;
  logic [3:0]  cpl_timeout_code;
  logic [3:0]  target_speed;
  logic        tx_deemph;
  logic        compliance_sos;
  logic        enter_compliance;
  logic        enter_mod_compliance;
  logic [2:0]  tx_margin;
  logic        autonomous_speed_ok;
  int          n_errors;
  int          n_tests;

  pxr_ext_cap_regs pxr_ext_cap_regs_inst (
    .mclk(mclk), .reset(reset), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .ee_wr(ee_wr),
    .ee_addr(ee_addr), .ee_wdata(ee_wdata),
    .root_complex_mode(root_complex_mode),
    .legacy_adapter_mode(legacy_adapter_mode), .func0_port0(func0_port0),
    .link_at_5gt(link_at_5gt), .in_poll_compliance(in_poll_compliance),
    .pme_event(pme_event), .cpl_timeout_code(cpl_timeout_code),
    .target_speed(target_speed), .tx_deemph(tx_deemph),
    .compliance_sos(compliance_sos), .enter_compliance(enter_compliance),
    .enter_mod_compliance(enter_mod_compliance), .tx_margin(tx_margin),
    .autonomous_speed_ok(autonomous_speed_ok));

  pxr_host_model pxr_host_model_inst (
    .mclk(mclk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack));

  // ***************************************
  // clock, watchdog, checking helpers
  // ***************************************
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // whole run is about 120 cycles; 5000 leaves ample margin
  initial begin
    #100000;
    n_errors++;
    test_done();
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // a read must be acked and carry the expected dword
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        k;
    pxr_host_model_inst.xfer(1'b0, a, 4'h0, 32'h0000_0000, d, k);
    chk_bit(k, 1'b1);
    chk_word(d, exp);
  endtask

  // a write is acked even when ignored, with read data at zero
  task automatic wr(input logic [11:0] a, input logic [3:0] be,
                    input logic [31:0] wd);
    logic [31:0] d;
    logic        k;
    pxr_host_model_inst.xfer(1'b1, a, be, wd, d, k);
    chk_bit(k, 1'b1);
    chk_word(d, 32'h0000_0000);
  endtask

  // eeprom preload: one-cycle strobe, then lines inverted
  task automatic ee_load(input logic [11:0] a, input logic [31:0] d);
    tick(1);
    ee_wr    = 1'b1;
    ee_addr  = a;
    ee_wdata = d;
    tick(1);
    ee_wr    = 1'b0;
    ee_addr  = ~a;
    ee_wdata = ~d;
  endtask

  // ***************************************
  // scenarios
  // ***************************************
  task automatic t_reset_ids();
    chk_word({28'h0, cpl_timeout_code}, 32'h0000_0003);
    chk_bit(autonomous_speed_ok, 1'b1);
    rd(PXR_OFS_DEV_CTL2, 32'h0000_0003);
    rd(PXR_OFS_DEV_CAP2, 32'h0000_0000);
    rd(PXR_OFS_SN_HDR, 32'hfb41_0003);
    rd(PXR_OFS_PB_HDR, 32'h1481_0004);
    rd(PXR_OFS_VC_HDR, 32'h9501_0002);
    rd(PXR_OFS_VC_CAP1, 32'h0000_0000);
    rd(PXR_OFS_SN_LOW, PXR_SN_LOW_RST);
    rd(PXR_OFS_SN_HIGH, PXR_SN_HIGH_RST);
    wr(PXR_OFS_SN_HIGH, 4'hf, 32'hffff_ffff);
    rd(PXR_OFS_SN_HIGH, PXR_SN_HIGH_RST);
    ee_load(PXR_OFS_SN_HIGH, 32'h00a5_c311);
    rd(PXR_OFS_SN_HIGH, 32'h00a5_c311);
    rd(12'h1c0, 32'h0000_0000);
  endtask

  task automatic t_root_pme();
    root_complex_mode = 1'b0;
    rd(PXR_OFS_ROOT_STAT, 32'h0000_0000);
    root_complex_mode = 1'b1;
    tick(1);
    pme_event = 1'b1;
    tick(1);
    pme_event = 1'b0;
    rd(PXR_OFS_ROOT_STAT, 32'h0001_0000);
    wr(PXR_OFS_ROOT_STAT, 4'hf, 32'h0001_0000);
    rd(PXR_OFS_ROOT_STAT, 32'h0000_0000);
    // preload fills requester id and pending only; status stays clear
    ee_load(PXR_OFS_ROOT_STAT, 32'hffff_ffff);
    rd(PXR_OFS_ROOT_STAT, 32'h0002_ffff);
    wr(PXR_OFS_ROOT_STAT, 4'hf, 32'hfffe_ffff);
    rd(PXR_OFS_ROOT_STAT, 32'h0002_ffff);
  endtask

  task automatic t_timeout();
    logic [3:0] codes [3] = '{4'h0, 4'h2, 4'h6};
    foreach (codes[i]) begin
      wr(PXR_OFS_DEV_CTL2, 4'hf, {28'h0, codes[i]});
      chk_word({28'h0, cpl_timeout_code}, {28'h0, codes[i]});
      rd(PXR_OFS_DEV_CTL2, {28'h0, codes[i]});
    end
    wr(PXR_OFS_DEV_CTL2, 4'hf, 32'hffff_ffff);
    rd(PXR_OFS_DEV_CTL2, 32'h0000_001f);
  endtask

  task automatic t_link_ctl();
    legacy_adapter_mode = 1'b0;
    wr(PXR_OFS_LINK_CTL2, 4'hf, 32'h0000_0001);
    rd(PXR_OFS_LINK_CTL2, 32'h0000_0000);
    legacy_adapter_mode = 1'b1;
    rd(PXR_OFS_LINK_CTL2, 32'h0000_0002);
    // speed 2.5, margin 5, compliance bits 4/10/11/12, reserved bit 5
    wr(PXR_OFS_LINK_CTL2, 4'hf, 32'hffff_1eb1);
    rd(PXR_OFS_LINK_CTL2, 32'h0000_1e91);
    chk_word({28'h0, target_speed}, {28'h0, PXR_SPEED_2G5});
    chk_bit(compliance_sos, 1'b1);
    chk_bit(enter_compliance, 1'b1);
    chk_word({29'h0, tx_margin}, 32'h0000_0005);
    chk_bit(enter_mod_compliance, 1'b0);
    func0_port0 = 1'b1;
    #1;
    chk_bit(enter_mod_compliance, 1'b1);
    chk_bit(autonomous_speed_ok, 1'b1);
    in_poll_compliance = 1'b1;
    tick(2);
    chk_bit(tx_deemph, 1'b1);
    rd(PXR_OFS_LINK_CTL2, 32'h0001_1e91);
    in_poll_compliance = 1'b0;
    tick(2);
    chk_bit(tx_deemph, PXR_DEEMPH_6DB);
    link_at_5gt = 1'b0;
    tick(2);
    chk_bit(tx_deemph, PXR_DEEMPH_3DB5);
    // reserved speed code through byte lane 0 only
    wr(PXR_OFS_LINK_CTL2, 4'h1, 32'hffff_ff03);
    chk_word({28'h0, target_speed}, {28'h0, PXR_SPEED_5G});
    rd(PXR_OFS_LINK_CTL2, 32'h0001_1e03);
    // selectable bit preloaded high picks -3.5 dB at 5 GT/s
    link_at_5gt = 1'b1;
    ee_load(PXR_OFS_LINK_CTL2, 32'h0000_0042);
    tick(2);
    chk_bit(tx_deemph, PXR_DEEMPH_3DB5);
    rd(PXR_OFS_LINK_CTL2, 32'h0001_0042);
  endtask

  task automatic t_power_budget();
    // index is always set before the entry it selects
    ee_load(PXR_OFS_PB_INDEX, 32'h0000_0000);
    ee_load(PXR_OFS_PB_ENTRY, 32'hffff_ffff);
    ee_load(PXR_OFS_PB_INDEX, 32'h0000_0001);
    ee_load(PXR_OFS_PB_ENTRY, 32'h0005_2d5a);
    rd(PXR_OFS_PB_INDEX, 32'h0000_0001);
    wr(PXR_OFS_PB_INDEX, 4'hf, 32'hffff_ff00);
    rd(PXR_OFS_PB_INDEX, 32'h0000_0000);
    rd(PXR_OFS_PB_ENTRY, 32'h001f_e3ff);
    wr(PXR_OFS_PB_INDEX, 4'hf, 32'h0000_0001);
    rd(PXR_OFS_PB_ENTRY, 32'h0005_215a);
    wr(PXR_OFS_PB_INDEX, 4'hf, 32'h0000_0002);
    rd(PXR_OFS_PB_ENTRY, 32'h0000_0000);
    rd(PXR_OFS_PB_FLAGS, 32'h0000_0001);
    wr(PXR_OFS_PB_ENTRY, 4'hf, 32'h0000_0000);
    rd(PXR_OFS_PB_INDEX, 32'h0000_0002);
  endtask

  // ***************************************
  // main sequence
  // ***************************************
  initial begin
    n_errors            = 0;
    n_tests             = 0;
    reset               = 1'b1;
    ee_wr               = 1'b0;
    ee_addr             = 12'h000;
    ee_wdata            = 32'h0000_0000;
    root_complex_mode   = 1'b0;
    legacy_adapter_mode = 1'b1;
    func0_port0         = 1'b0;
    link_at_5gt         = 1'b1;
    in_poll_compliance  = 1'b0;
    pme_event           = 1'b0;
    tick(3);
    reset = 1'b0;
    t_reset_ids();
    t_root_pme();
    t_timeout();
    t_link_ctl();
    t_power_budget();
    tick(2);
    test_done();
  end
endmodule
